/* File: fskst_regs.svh */
// register offsets, field positions, reset values and codes of the fsk shaper block
`ifndef FSKST_REGS_SVH
`define FSKST_REGS_SVH
`define FSKST_ADDR_CLK_CFG 8'h00
`define FSKST_ADDR_DEV_CFG 8'h04
`define FSKST_ADDR_TRIM 8'h08
`define FSKST_ADDR_FEC_CTRL 8'h0c
`define FSKST_ADDR_FEC_STAT 8'h10
`define FSKST_RST_REF_DIV 6'h01
`define FSKST_RST_CLK_SCALE 3'h0
`define FSKST_RST_CURRENT 5'h00
`define FSKST_RST_ATTEN 4'h0
`define FSKST_RST_FILTER 3'h0
`define FSKST_RST_TRIM 5'h10
`define FSKST_RST_WIN_SEL 2'h0
`define FSKST_RST_CNT_MODE 2'h3
`define FSKST_SCALE_TOP 3'h7
`define FSKST_WIN_BASE 7'h08
`define FSKST_EDGE_TICKS 3'h4
`define FSKST_MODE_UP_BIT 0
`define FSKST_MODE_DN_BIT 1
`define FSKST_RESP_OKAY 2'h0
`define FSKST_RESP_SLVERR 2'h2
`endif

/* File: fskst_pkg.sv */
// types shared by the fsk shaper and error counter modules
package fskst_pkg;
  typedef enum logic {SH_IDLE, SH_EDGE} fskst_sh_state_t;
  typedef enum logic {FC_IDLE, FC_RUN} fskst_fc_state_t;
  typedef logic [7:0] fskst_addr_t;
  typedef logic [31:0] fskst_word_t;
endpackage : fskst_pkg

/* File: fskst_fec_if.sv */
// link between register file and frequency error counter
`timescale 1ns/10ps
interface fskst_fec_if;
  logic start;
  logic [1:0] win_sel;
  logic [1:0] cnt_mode;
  logic bit_tick;
  logic up_pulse;
  logic down_pulse;
  logic [7:0] count;
  logic busy;
  logic done;
  modport ctl (output start, win_sel, cnt_mode, bit_tick, up_pulse, down_pulse,
               input count, busy, done);
  modport cnt (input start, win_sel, cnt_mode, bit_tick, up_pulse, down_pulse,
               output count, busy, done);
endinterface : fskst_fec_if

/* File: fskst_err_cnt.sv */
// frequency error counter over a window of received bits
`timescale 1ns/10ps
`include "fskst_regs.svh"
module fskst_err_cnt (
  input wire logic ref_clk_in, // block clock
  input wire logic sys_rst_in, // sync reset, high
  fskst_fec_if.cnt fec // control and result
);
  import fskst_pkg::*;
  typedef struct packed {
    fskst_fc_state_t st;
    logic [6:0] bits;
    logic [6:0] n;
    logic [7:0] cnt;
    logic done;
  } fskst_fc_reg_t;
  fskst_fc_reg_t q;
  fskst_fc_reg_t d;
  logic inc;
  logic dec;
  logic [6:0] helper_ticks_q;

  ////////////////////////////////////////////////////////////////////////////
  // pulse selection: up counts upward, down counts downward
  assign inc = fec.cnt_mode[`FSKST_MODE_UP_BIT] & fec.up_pulse;
  assign dec = fec.cnt_mode[`FSKST_MODE_DN_BIT] & fec.down_pulse;

  // next state of the counter
  always_comb begin
    d = q;
    if (q.st == FC_RUN) begin
      d.cnt = q.cnt + {7'h00, inc} - {7'h00, dec};
      if (fec.bit_tick) begin
        d.bits = q.bits + 7'h01;
        if (d.bits == q.n) begin
          d.st = FC_IDLE;
          d.done = 1'b1;
        end
      end
    end
    if (fec.start) begin
      d.st = FC_RUN;
      d.cnt = 8'h00;
      d.bits = 7'h00;
      d.n = `FSKST_WIN_BASE << fec.win_sel;
      d.done = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fec.count = q.cnt;
  assign fec.busy = (q.st == FC_RUN);
  assign fec.done = q.done;

  ////////////////////////////////////////////////////////////////////////////
  // helper: bit ticks seen during a window
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || fec.start) begin
      helper_ticks_q <= 7'h00;
    end else if (fec.busy && fec.bit_tick) begin
      helper_ticks_q <= helper_ticks_q + 7'h01;
    end
  end

  chk_window_len: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $fell(fec.busy) && !$past(fec.start) |-> helper_ticks_q == q.n && fec.done)
    else $error("window did not end after n bits");
  chk_clear_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    fec.start |=> fec.count == 8'h00 && fec.busy)
    else $error("count not cleared at window start");
  chk_hold_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !fec.busy && !fec.start |=> $stable(fec.count))
    else $error("count moved outside a window");
  chk_up_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    fec.busy && !fec.start && inc && !dec |=> fec.count == 8'($past(fec.count) + 8'h01))
    else $error("up pulse not counted upward");
  chk_down_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    fec.busy && !fec.start && dec && !inc |=> fec.count == 8'($past(fec.count) - 8'h01))
    else $error("down pulse not counted downward");
  chk_wrap_top: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    fec.busy && !fec.start && fec.count == 8'h7f && inc && !dec |=> fec.count == 8'h80)
    else $error("count saturated instead of wrapping");
endmodule : fskst_err_cnt

/* File: fskst_top.sv */
// fsk shaping clock, waveform edge sequencer, trim and error counter registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "fskst_regs.svh"
// Functional notes
// - shaping tick period is ref divider times two to seven minus scale
// - scale code accepts 0..7, each step doubles shaping clock rate
// - five-bit charge current code 0..31, larger code gives larger deviation
// - attenuator code 0..15, deviation scales by one over one plus code
// - filter code zero disables smoothing; seven filters most
// - higher trim code adds load capacitance, lowering oscillator frequency
// - error counter window is 8, 16, 32 or 64 received bits
// - count up pulses upward, down pulses downward, either or both
// - error count is eight-bit two's complement, wraps without saturating
// - each waveform rising or falling edge spends four shaping ticks
module fskst_top (
  input wire logic ref_clk_in, // 250 MHz clock
  input wire logic sys_rst_in, // sync reset, high
  input wire fskst_pkg::fskst_addr_t s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire fskst_pkg::fskst_word_t s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire fskst_pkg::fskst_addr_t s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output fskst_pkg::fskst_word_t s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  input wire logic tx_data_in, // modulation data pin
  input wire logic rx_bit_in, // received bit clock pin
  input wire logic up_pulse_in, // demodulator up pulse pin
  input wire logic down_pulse_in, // demodulator down pulse pin
  output logic shaping_tick_out, // one cycle per shaping period
  output logic shape_active_out, // edge in progress
  output logic shape_rising_out, // edge direction
  output logic [1:0] shape_step_out, // period within edge
  output logic [4:0] charge_current_out, // charge current code
  output logic [3:0] atten_out, // attenuator code
  output logic [2:0] filter_code_out, // smoothing filter code
  output logic filter_enable_out, // smoothing filter on
  output logic [4:0] trim_code_out // crystal trim code
);
  import fskst_pkg::*;
  typedef struct packed {
    logic [5:0] ref_div;
    logic [2:0] shaping_clock_scale;
    logic [4:0] current;
    logic [3:0] atten;
    logic [2:0] filter;
    logic [4:0] trim;
    logic [1:0] win_sel;
    logic [1:0] cnt_mode;
    logic start;
    logic [7:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [12:0] div_cnt;
    logic tick;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    fskst_sh_state_t sh_st;
    logic level;
    logic [1:0] step;
  } fskst_top_reg_t;
  fskst_top_reg_t q;
  fskst_top_reg_t d;
  fskst_fec_if fec ();
  logic wr_fire;
  logic [31:0] wr_word;
  logic [12:0] period;
  logic [5:0] div_eff;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // current word image of a register, also the read data
  function automatic logic [31:0] reg_word(input fskst_top_reg_t s, input logic [7:0] a,
                                           input logic [7:0] cnt, input logic busy,
                                           input logic done);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `FSKST_ADDR_CLK_CFG: r = {21'h0, s.shaping_clock_scale, 2'h0, s.ref_div};
      `FSKST_ADDR_DEV_CFG: r = {13'h0, s.filter, 4'h0, s.atten, 3'h0, s.current};
      `FSKST_ADDR_TRIM: r = {27'h0, s.trim};
      `FSKST_ADDR_FEC_CTRL: r = {26'h0, s.cnt_mode, 2'h0, s.win_sel};
      `FSKST_ADDR_FEC_STAT: r = {22'h0, done, busy, cnt};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : reg_word

  ////////////////////////////////////////////////////////////////////////////
  // zero divider is illegal; treat it as one so the tick never stalls
  assign div_eff = (q.ref_div == 6'h00) ? 6'h01 : q.ref_div;
  assign period = {7'h00, div_eff} << (`FSKST_SCALE_TOP - q.shaping_clock_scale);
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign wr_word = merge(reg_word(q, q.aw_addr, fec.count, fec.busy, fec.done), q.w_data,
                         q.w_strb);

  // next state: bus slave, divider, pin sync, edge sequencer
  always_comb begin
    d = q;
    d.start = 1'b0;
    if (s_axi_awvalid_in && !q.aw_got) begin
      d.aw_addr = s_axi_awaddr_in;
      d.aw_got = 1'b1;
    end
    if (s_axi_wvalid_in && !q.w_got) begin
      d.w_data = s_axi_wdata_in;
      d.w_strb = s_axi_wstrb_in;
      d.w_got = 1'b1;
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `FSKST_RESP_OKAY;
      case (q.aw_addr)
        `FSKST_ADDR_CLK_CFG: begin
          d.ref_div = wr_word[5:0];
          d.shaping_clock_scale = wr_word[10:8];
        end
        `FSKST_ADDR_DEV_CFG: begin
          d.current = wr_word[4:0];
          d.atten = wr_word[11:8];
          d.filter = wr_word[18:16];
        end
        `FSKST_ADDR_TRIM: d.trim = wr_word[4:0];
        `FSKST_ADDR_FEC_CTRL: begin
          d.win_sel = wr_word[1:0];
          d.cnt_mode = wr_word[5:4];
          d.start = q.w_strb[1] && q.w_data[8];
        end
        `FSKST_ADDR_FEC_STAT: d.bresp = `FSKST_RESP_OKAY;
        default: d.bresp = `FSKST_RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = reg_word(q, s_axi_araddr_in, fec.count, fec.busy, fec.done);
      d.rresp = (s_axi_araddr_in > `FSKST_ADDR_FEC_STAT || s_axi_araddr_in[1:0] != 2'h0)
                ? `FSKST_RESP_SLVERR : `FSKST_RESP_OKAY;
    end
    // shaping clock divider
    d.tick = 1'b0;
    if (q.div_cnt >= period - 13'h0001) begin
      d.div_cnt = 13'h0000;
      d.tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 13'h0001;
    end
    // pins: two flops, third for edge detection
    d.sync1 = {down_pulse_in, up_pulse_in, rx_bit_in, tx_data_in};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    // edge sequencer: four shaping ticks per edge
    case (q.sh_st)
      SH_IDLE: begin
        if (q.sync2[0] != q.level) begin
          d.sh_st = SH_EDGE;
          d.level = q.sync2[0];
          d.step = 2'h0;
        end
      end
      SH_EDGE: begin
        if (q.tick) begin
          d.step = q.step + 2'h1;
          if ({1'b0, q.step} == `FSKST_EDGE_TICKS - 3'h1) begin
            d.sh_st = SH_IDLE;
          end
        end
      end
      default: d.sh_st = SH_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.ref_div <= `FSKST_RST_REF_DIV;
      q.shaping_clock_scale <= `FSKST_RST_CLK_SCALE;
      q.current <= `FSKST_RST_CURRENT;
      q.atten <= `FSKST_RST_ATTEN;
      q.filter <= `FSKST_RST_FILTER;
      q.trim <= `FSKST_RST_TRIM;
      q.win_sel <= `FSKST_RST_WIN_SEL;
      q.cnt_mode <= `FSKST_RST_CNT_MODE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error counter and its pulse feeds
  assign fec.start = q.start;
  assign fec.win_sel = q.win_sel;
  assign fec.cnt_mode = q.cnt_mode;
  assign fec.bit_tick = q.sync2[1] && !q.sync3[1];
  assign fec.up_pulse = q.sync2[2] && !q.sync3[2];
  assign fec.down_pulse = q.sync2[3] && !q.sync3[3];

  fskst_err_cnt u_err_cnt (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .fec(fec.cnt)
  );

  // outputs
  assign s_axi_awready_out = !q.aw_got;
  assign s_axi_wready_out = !q.w_got;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;
  assign shaping_tick_out = q.tick;
  assign shape_active_out = (q.sh_st == SH_EDGE);
  assign shape_rising_out = q.level;
  assign shape_step_out = q.step;
  assign charge_current_out = q.current;
  assign atten_out = q.atten;
  assign filter_code_out = q.filter;
  assign filter_enable_out = (q.filter != 3'h0);
  assign trim_code_out = q.trim;

  ////////////////////////////////////////////////////////////////////////////
  // helpers: cycles between ticks, config change, ticks in an edge
  logic [12:0] gap_q;
  logic gap_ok_q;
  logic [2:0] edge_ticks_q;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      gap_q <= 13'h0000;
      gap_ok_q <= 1'b0;
      edge_ticks_q <= 3'h0;
    end else begin
      gap_q <= q.tick ? 13'h0001 : gap_q + 13'h0001;
      if (wr_fire && q.aw_addr == `FSKST_ADDR_CLK_CFG) begin
        gap_ok_q <= 1'b0;
      end else if (q.tick) begin
        gap_ok_q <= 1'b1;
      end
      if (!shape_active_out) begin
        edge_ticks_q <= 3'h0;
      end else if (q.tick) begin
        edge_ticks_q <= edge_ticks_q + 3'h1;
      end
    end
  end

  sequence s_edge_done;
    $fell(shape_active_out);
  endsequence

  chk_tick_period: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    q.tick && gap_ok_q && !(wr_fire && q.aw_addr == `FSKST_ADDR_CLK_CFG) |-> gap_q == period)
    else $error("shaping tick period wrong");
  chk_scale_fast: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    q.ref_div == 6'h01 && q.shaping_clock_scale == 3'h7 && $stable(q.ref_div)
    && $stable(q.shaping_clock_scale) |=> shaping_tick_out)
    else $error("top scale code does not tick every cycle");
  chk_edge_ticks: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_edge_done |-> edge_ticks_q == `FSKST_EDGE_TICKS)
    else $error("edge did not span four shaping ticks");
  chk_current_wr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_fire && q.aw_addr == `FSKST_ADDR_DEV_CFG && q.w_strb[0]
    |=> charge_current_out == $past(q.w_data[4:0]))
    else $error("charge current not taken from write");
  chk_atten_wr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_fire && q.aw_addr == `FSKST_ADDR_DEV_CFG && q.w_strb[1]
    |=> atten_out == $past(q.w_data[11:8]))
    else $error("attenuator not taken from write");
  chk_filter_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    filter_enable_out == (filter_code_out != 3'h0))
    else $error("filter enable disagrees with code");
  chk_trim_wr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_fire && q.aw_addr == `FSKST_ADDR_TRIM && q.w_strb[0]
    |=> trim_code_out == $past(q.w_data[4:0]))
    else $error("trim code not taken from write");
endmodule : fskst_top

/* File: fskst_demod_model.sv */
// demodulator model: received bit clock and up or down pulses per bit
`timescale 1ns/10ps
module fskst_demod_model (
  input wire logic ref_clk_in, // block clock
  output logic rx_bit_out, // received bit clock
  output logic up_pulse_out, // up pulse pin
  output logic down_pulse_out // down pulse pin
);
  // pins idle low until a bit is sent
  initial begin
    rx_bit_out = 1'h0;
    up_pulse_out = 1'h0;
    down_pulse_out = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulses first, then the bit clock edge; hold sets a prompt or slow pace
  task automatic send_bit(input logic val, input int per, input int hold);
    int i;
    for (i = 0; i < per; i++) begin
      @(posedge ref_clk_in);
      if (val) begin
        up_pulse_out <= 1'h1;
      end else begin
        down_pulse_out <= 1'h1;
      end
      repeat (hold) @(posedge ref_clk_in);
      up_pulse_out <= 1'h0;
      down_pulse_out <= 1'h0;
      repeat (hold) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    rx_bit_out <= 1'h1;
    repeat (hold) @(posedge ref_clk_in);
    rx_bit_out <= 1'h0;
    repeat (hold) @(posedge ref_clk_in);
  endtask : send_bit
endmodule : fskst_demod_model

/* File: fskst_top_test.sv */
// self-checking bench for the fsk shaper and error counter block
`timescale 1ns/10ps
`include "fskst_regs.svh"
module fskst_top_test;
  import fskst_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  fskst_addr_t awaddr = 8'h00;
  fskst_addr_t araddr = 8'h00;
  fskst_word_t wdata = 32'h0;
  fskst_word_t rdata;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic tx = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tick, act, rise, fen, rxb, upp, dnp;
  logic [1:0] bresp, rresp, step;
  logic [4:0] cur, trim;
  logic [3:0] att;
  logic [2:0] filt;
  int failures = 0;
  int n_tests = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // block and its demodulator partner
  fskst_top dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .tx_data_in(tx), .rx_bit_in(rxb), .up_pulse_in(upp),
    .down_pulse_in(dnp), .shaping_tick_out(tick), .shape_active_out(act),
    .shape_rising_out(rise), .shape_step_out(step), .charge_current_out(cur),
    .atten_out(att), .filter_code_out(filt), .filter_enable_out(fen), .trim_code_out(trim)
  );
  fskst_demod_model model_u (
    .ref_clk_in(clk), .rx_bit_out(rxb), .up_pulse_out(upp), .down_pulse_out(dnp)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // compare one value
  task automatic check(input fskst_word_t seen, input fskst_word_t want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
    end
  endtask : check
  // a wait that ran out
  task automatic give_up();
    failures++;
    $display("wrong value at %0t ns: wait limit reached", $time);
    complete_run();
  endtask : give_up
  ////////////////////////////////////////////////////////////////////////////////
  // one write, address and data offered together, response compared
  task automatic wr(input fskst_addr_t a, input fskst_word_t d, input logic [1:0] r);
    int i;
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    i = 0;
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    do begin
      if (++i > 200) give_up();
      @(posedge clk);
      if (awvalid && awready) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end while (!(aw_ok && w_ok));
    bready <= 1'h1;
    do begin
      if (++i > 400) give_up();
      @(posedge clk);
    end while (bvalid !== 1'h1);
    check({30'h0, bresp}, {30'h0, r});
    bready <= 1'h0;
  endtask : wr
  // one read, data and response returned
  task automatic rd(input fskst_addr_t a, output fskst_word_t d, output logic [1:0] r);
    int i;
    i = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      if (++i > 200) give_up();
      @(posedge clk);
    end while (!(arvalid && arready));
    arvalid <= 1'h0;
    rready <= 1'h1;
    do begin
      if (++i > 400) give_up();
      @(posedge clk);
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
  // read and compare data and response
  task automatic rdc(input fskst_addr_t a, input fskst_word_t d, input logic [1:0] r);
    fskst_word_t got;
    logic [1:0] gr;
    rd(a, got, gr);
    check(got, d);
    check({30'h0, gr}, {30'h0, r});
  endtask : rdc
  // cycles until the next shaping tick
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      if (++n > 600) give_up();
      @(posedge clk);
    end while (tick !== 1'h1);
  endtask : wait_tick
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped and unaligned places, read-only status
  task automatic t_map();
    check({27'h0, trim}, 32'h10);
    rdc(`FSKST_ADDR_CLK_CFG, 32'h1, `FSKST_RESP_OKAY);
    rdc(`FSKST_ADDR_FEC_CTRL, 32'h30, `FSKST_RESP_OKAY);
    rdc(8'h14, 32'h0, `FSKST_RESP_SLVERR);
    wr(8'h14, 32'hffff_ffff, `FSKST_RESP_SLVERR);
    wr(8'h06, 32'hffff_ffff, `FSKST_RESP_SLVERR);
    wr(`FSKST_ADDR_FEC_STAT, 32'hffff_ffff, `FSKST_RESP_OKAY);
    rdc(`FSKST_ADDR_FEC_STAT, 32'h0, `FSKST_RESP_OKAY);
    rdc(`FSKST_ADDR_TRIM, 32'h10, `FSKST_RESP_OKAY);
  endtask : t_map
  // tick period over a table of divider and scale codes
  task automatic t_tick();
    int div[5] = '{3, 1, 63, 2, 5};
    int scl[5] = '{5, 7, 6, 0, 3};
    int k;
    int n;
    for (k = 0; k < 5; k++) begin
      wr(`FSKST_ADDR_CLK_CFG, 32'(scl[k] * 256 + div[k]), `FSKST_RESP_OKAY);
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check(32'(n), 32'(div[k] << (7 - scl[k])));
    end
  endtask : t_tick
  // each waveform edge spans four shaping periods, both directions
  task automatic t_edge();
    int i;
    int n;
    int k;
    wr(`FSKST_ADDR_CLK_CFG, 32'h0000_0601, `FSKST_RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      tx <= (k == 0);
      i = 0;
      n = 0;
      do begin
        if (++i > 60) give_up();
        @(posedge clk);
      end while (act !== 1'h1);
      check({31'h0, rise}, {31'h0, k == 0});
      while (act === 1'h1) begin
        if (tick === 1'h1) n++;
        if (++i > 120) give_up();
        @(posedge clk);
      end
      check(32'(n), 32'h4);
    end
  endtask : t_edge
  // deviation and trim codes reach their outputs
  task automatic t_dev();
    logic [4:0] c[3] = '{5'h1f, 5'h00, 5'h15};
    logic [3:0] a[3] = '{4'hf, 4'h0, 4'ha};
    logic [2:0] f[3] = '{3'h7, 3'h0, 3'h1};
    int k;
    for (k = 0; k < 3; k++) begin
      wr(`FSKST_ADDR_DEV_CFG, {13'h0, f[k], 4'h0, a[k], 3'h0, c[k]}, `FSKST_RESP_OKAY);
      check({27'h0, cur}, {27'h0, c[k]});
      check({28'h0, att}, {28'h0, a[k]});
      check({28'h0, fen, filt}, {28'h0, f[k] != 3'h0, f[k]});
      wr(`FSKST_ADDR_TRIM, {27'h0, c[k]}, `FSKST_RESP_OKAY);
      check({27'h0, trim}, {27'h0, c[k]});
    end
  endtask : t_dev
  // one count window; expected count worked out from mode and pattern
  task automatic t_win(input logic [1:0] sel, input logic [1:0] mode, input int ones,
                       input int per);
    fskst_word_t d;
    logic [1:0] r;
    logic [7:0] want;
    int k;
    int i;
    want = 8'((mode[0] ? ones * per : 0) - (mode[1] ? ((8 << sel) - ones) * per : 0));
    wr(`FSKST_ADDR_FEC_CTRL, {23'h0, 1'h1, 2'h0, mode, 2'h0, sel}, `FSKST_RESP_OKAY);
    rdc(`FSKST_ADDR_FEC_STAT, 32'h100, `FSKST_RESP_OKAY);
    for (k = 0; k < (8 << sel); k++) model_u.send_bit(k < ones, per, 3);
    i = 0;
    do begin
      if (++i > 20) give_up();
      rd(`FSKST_ADDR_FEC_STAT, d, r);
    end while (d[9] !== 1'h1);
    check(d, {22'h0, 2'h2, want});
    model_u.send_bit(1'h1, 2, 5);
    rdc(`FSKST_ADDR_FEC_STAT, {22'h0, 2'h2, want}, `FSKST_RESP_OKAY);
  endtask : t_win
  // host trim search on an alternating pattern; model offset is zero at trim 20
  task automatic t_cal();
    fskst_word_t d;
    logic [1:0] r;
    logic [4:0] present;
    logic pos;
    int step;
    int k;
    int i;
    present = 5'h00;
    step = 32;
    pos = 1'h0;
    wr(`FSKST_ADDR_CLK_CFG, 32'h0000_0701, `FSKST_RESP_OKAY);
    wr(`FSKST_ADDR_DEV_CFG, 32'h0000_001f, `FSKST_RESP_OKAY);
    do begin
      step = step / 2;
      present = pos ? present - 5'(step) : present + 5'(step);
      wr(`FSKST_ADDR_TRIM, {27'h0, present}, `FSKST_RESP_OKAY);
      wr(`FSKST_ADDR_FEC_CTRL, 32'h0000_0130, `FSKST_RESP_OKAY);
      // low trim means high oscillator: zeros get more pulses
      for (k = 0; k < 8; k++) begin
        model_u.send_bit(k[0] == 1'h0,
                         1 + ((k[0] == 1'h0) ? (trim > 5'h14) : (trim < 5'h14)), 3);
      end
      i = 0;
      do begin
        if (++i > 20) give_up();
        rd(`FSKST_ADDR_FEC_STAT, d, r);
      end while (d[9] !== 1'h1);
      pos = !d[7] && (d[7:0] != 8'h00);
    end while (step > 1);
    if (pos) present = present - 5'h01;
    check({27'h0, present}, 32'h14);
  endtask : t_cal
  ////////////////////////////////////////////////////////////////////////////////
  // reset, then every scenario in turn
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_map();
    t_tick();
    t_edge();
    t_dev();
    t_win(2'h0, 2'h3, 5, 1);
    t_win(2'h1, 2'h1, 10, 1);
    t_win(2'h2, 2'h2, 12, 1);
    t_win(2'h3, 2'h1, 64, 3);
    t_win(2'h3, 2'h2, 0, 3);
    t_cal();
    complete_run();
  end
endmodule : fskst_top_test
